// ===== verilog/mrs_defs.svh
// Function
// - Host fetches results in one burst
// - Temperature and pressure: burst 0xF7 to 0xFC
// - All three results: burst 0xF7 to 0xFE
// - Pressure, temperature 20-bit; humidity 16-bit unsigned
// - Conversions complete independent of host reads
// - Completion during burst goes to shadow
// - Shadow copied when burst ends
// - Burst end: select rising or STOP
// - All visible registers update same cycle
// - Unsynchronised host must read one burst
// - Skipped conversion loads 0x80000
`ifndef MRS_DEFS_SVH
`define MRS_DEFS_SVH
`define MRS_ADDR_FIRST 8'hF7
`define MRS_ADDR_LAST_TP 8'hFC
`define MRS_ADDR_LAST_TPH 8'hFE
`define MRS_ADDR_PRESS_MSB 8'hF7
`define MRS_ADDR_PRESS_MID 8'hF8
`define MRS_ADDR_PRESS_LOW 8'hF9
`define MRS_ADDR_TEMP_MSB 8'hFA
`define MRS_ADDR_TEMP_MID 8'hFB
`define MRS_ADDR_TEMP_LOW 8'hFC
`define MRS_ADDR_HUM_MSB 8'hFD
`define MRS_ADDR_HUM_LSB 8'hFE
`define MRS_PT_WIDTH 20
`define MRS_HUM_WIDTH 16
`define MRS_SKIPPED 20'h80000
`define MRS_HUM_RESET 16'h8000
`endif

// ===== verilog/mrs_pkg.sv
package mrs_pkg;
    typedef enum logic [1:0] {MRS_IDLE, MRS_ADDR, MRS_DATA, MRS_END} mrs_host_state_t;
    typedef struct packed {
        logic [19:0] press;
        logic [19:0] temp;
        logic [15:0] hum;
    } mrs_result_t;
endpackage

// ===== verilog/mrs_link_if.sv
`timescale 1ns/10ps
// Byte-level readout link: host addresses, device streams bytes
interface mrs_link_if;
    logic burst_active;
    logic [7:0] start_addr;
    logic start;
    logic byte_req;
    logic [7:0] rd_data;
    logic rd_valid;
    logic spi_mode;
    logic serial_select_low;
    logic i2c_stop;
    modport device (input burst_active, start_addr, start, byte_req, spi_mode, serial_select_low, i2c_stop,
        output rd_data, rd_valid);
    modport host (output burst_active, start_addr, start, byte_req, spi_mode, serial_select_low, i2c_stop,
        input rd_data, rd_valid);
endinterface

// ===== verilog/mrs_device.sv
`timescale 1ns/10ps
`include "mrs_defs.svh"
module mrs_device (
    input wire logic CLOCK, // System clock
    input wire logic SYS_RST, // Sync reset, high
    mrs_link_if.device LINK, // Readout link
    input wire logic CONV_DONE, // Conversion finished pulse
    input wire logic [19:0] CONV_PRESS, // Raw pressure
    input wire logic [19:0] CONV_TEMP, // Raw temperature
    input wire logic [15:0] CONV_HUM, // Raw humidity
    input wire logic SKIP_PRESS, // Pressure skipped
    input wire logic SKIP_TEMP, // Temperature skipped
    output logic SHADOW_PENDING // Shadow holds new set
);
    // Published set, pending shadow set and link tracking
    typedef struct packed {
        mrs_pkg::mrs_result_t vis;
        mrs_pkg::mrs_result_t shadow;
        logic pending;
        logic in_burst;
        logic sel_prev;
        logic [7:0] addr;
        logic [7:0] data;
        logic valid;
    } mrs_dev_state_t;

    mrs_dev_state_t st_reg, st_next;
    mrs_pkg::mrs_result_t fresh;
    logic sel_rise;
    logic burst_end;
    logic burst_close;
    logic serve;
    logic land_shadow;
    logic land_visible;
    logic publish;

    // Until the first conversion pressure and temperature read as skipped, humidity as 0x8000
    function automatic mrs_dev_state_t mrs_reset_state();
        mrs_dev_state_t s;
        s = '0;
        s.vis.press = `MRS_SKIPPED;
        s.vis.temp = `MRS_SKIPPED;
        s.vis.hum = `MRS_HUM_RESET;
        s.shadow.press = `MRS_SKIPPED;
        s.shadow.temp = `MRS_SKIPPED;
        s.shadow.hum = `MRS_HUM_RESET;
        s.sel_prev = 1'b1;
        mrs_reset_state = s;
    endfunction

    // Skipped measurement reads back as the fixed marker
    function automatic logic [19:0] mrs_pt_value(input logic skip, input logic [19:0] raw);
        if (skip) begin
            mrs_pt_value = `MRS_SKIPPED;
        end else begin
            mrs_pt_value = raw;
        end
    endfunction

    function automatic mrs_pkg::mrs_result_t mrs_result(input logic [19:0] press, input logic [19:0] temp,
        input logic [15:0] hum, input logic skip_press, input logic skip_temp);
        mrs_pkg::mrs_result_t r;
        r.press = mrs_pt_value(skip_press, press);
        r.temp = mrs_pt_value(skip_temp, temp);
        r.hum = hum;
        mrs_result = r;
    endfunction

    // Every field from one source, so no mix of two sets
    function automatic mrs_pkg::mrs_result_t mrs_copy(input mrs_pkg::mrs_result_t src);
        mrs_pkg::mrs_result_t d;
        d.press = src.press;
        d.temp = src.temp;
        d.hum = src.hum;
        mrs_copy = d;
    endfunction

    // 20-bit values: upper, middle, then low nibble left-aligned
    function automatic logic [7:0] mrs_msb(input logic [19:0] v);
        mrs_msb = v[19:12];
    endfunction

    function automatic logic [7:0] mrs_mid(input logic [19:0] v);
        mrs_mid = v[11:4];
    endfunction

    function automatic logic [7:0] mrs_low(input logic [19:0] v);
        mrs_low = {v[3:0], 4'h0};
    endfunction

    // Byte seen by the host at one result address
    function automatic logic [7:0] mrs_byte(input mrs_pkg::mrs_result_t r, input logic [7:0] a);
        case (a)
            `MRS_ADDR_PRESS_MSB: begin
                mrs_byte = mrs_msb(r.press);
            end
            `MRS_ADDR_PRESS_MID: begin
                mrs_byte = mrs_mid(r.press);
            end
            `MRS_ADDR_PRESS_LOW: begin
                mrs_byte = mrs_low(r.press);
            end
            `MRS_ADDR_TEMP_MSB: begin
                mrs_byte = mrs_msb(r.temp);
            end
            `MRS_ADDR_TEMP_MID: begin
                mrs_byte = mrs_mid(r.temp);
            end
            `MRS_ADDR_TEMP_LOW: begin
                mrs_byte = mrs_low(r.temp);
            end
            `MRS_ADDR_HUM_MSB: begin
                mrs_byte = r.hum[15:8];
            end
            `MRS_ADDR_HUM_LSB: begin
                mrs_byte = r.hum[7:0];
            end
            default: begin
                mrs_byte = 8'h00;
            end
        endcase
    endfunction

    // Auto-increment across the result span
    function automatic logic [7:0] mrs_addr_step(input logic [7:0] a);
        mrs_addr_step = a + 8'h01;
    endfunction

    // SPI select pin level went from selected to released
    function automatic logic mrs_sel_rise(input logic now_level, input logic prev_level);
        mrs_sel_rise = now_level && !prev_level;
    endfunction

    function automatic logic mrs_end_mark(input logic spi, input logic rise, input logic stop);
        if (spi) begin
            mrs_end_mark = rise;
        end else begin
            mrs_end_mark = stop;
        end
    endfunction

    // Burst flag: opened by start, closed by end mark or dropped burst
    function automatic logic mrs_burst_next(input logic open, input logic close, input logic now);
        if (open) begin
            mrs_burst_next = 1'b1;
        end else if (close) begin
            mrs_burst_next = 1'b0;
        end else begin
            mrs_burst_next = now;
        end
    endfunction

    always_comb begin
        fresh = mrs_result(CONV_PRESS, CONV_TEMP, CONV_HUM, SKIP_PRESS, SKIP_TEMP);
        sel_rise = mrs_sel_rise(LINK.serial_select_low, st_reg.sel_prev);
        burst_end = st_reg.in_burst && mrs_end_mark(LINK.spi_mode, sel_rise, LINK.i2c_stop);
        // A host that drops the burst without an end mark still releases it
        burst_close = st_reg.in_burst && (burst_end || !LINK.burst_active);
        serve = st_reg.in_burst && LINK.byte_req;
        land_shadow = CONV_DONE && st_reg.in_burst && !burst_close;
        land_visible = CONV_DONE && !land_shadow;
        publish = burst_close && st_reg.pending && !CONV_DONE;

        st_next = st_reg;
        st_next.sel_prev = LINK.serial_select_low;
        st_next.valid = 1'b0;
        st_next.in_burst = mrs_burst_next(LINK.start, burst_close, st_reg.in_burst);
        if (LINK.start) begin
            st_next.addr = LINK.start_addr;
        end

        // One byte per request, always from the published set
        if (serve) begin
            st_next.data = mrs_byte(st_reg.vis, st_reg.addr);
            st_next.valid = 1'b1;
            st_next.addr = mrs_addr_step(st_reg.addr);
        end

        // A completion mid-burst waits; a newer one replaces it
        if (land_shadow) begin
            st_next.shadow = fresh;
            st_next.pending = 1'b1;
        end
        // Outside a burst, or on its closing edge, straight to view
        if (land_visible) begin
            st_next.vis = mrs_copy(fresh);
            st_next.pending = 1'b0;
        end

        // Whole set published in one edge
        if (publish) begin
            st_next.vis = mrs_copy(st_reg.shadow);
            st_next.pending = 1'b0;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            st_reg <= mrs_reset_state();
        end else begin
            st_reg <= st_next;
        end
    end

    // Link outputs straight from flip-flops
    assign LINK.rd_data = st_reg.data;
    assign LINK.rd_valid = st_reg.valid;
    assign SHADOW_PENDING = st_reg.pending;
endmodule // mrs_device

// ===== verilog/mrs_host.sv
`timescale 1ns/10ps
`include "mrs_defs.svh"
module mrs_host (
    input wire logic CLOCK, // System clock
    input wire logic SYS_RST, // Sync reset, high
    mrs_link_if.host LINK, // Readout link
    input wire logic READ_REQ, // Start a readout pulse
    input wire logic WITH_HUM, // Include humidity
    input wire logic USE_SPI, // SPI end marking
    output logic BUSY, // Readout running
    output logic DONE, // Result set ready pulse
    output logic [19:0] PRESS, // Raw pressure
    output logic [19:0] TEMP, // Raw temperature
    output logic [15:0] HUM // Raw humidity
);
    typedef struct packed {
        mrs_pkg::mrs_host_state_t state;
        logic [7:0] last;
        logic [3:0] count;
        logic [63:0] shift;
        logic spi;
        logic done;
        mrs_pkg::mrs_result_t res;
    } mrs_host_st_t;
    mrs_host_st_t st_reg, st_next;

    always_comb begin
        st_next = st_reg;
        st_next.done = 1'b0;
        case (st_reg.state)
            mrs_pkg::MRS_IDLE: begin
                if (READ_REQ) begin
                    st_next.state = mrs_pkg::MRS_ADDR;
                    st_next.spi = USE_SPI;
                    st_next.last = WITH_HUM ? `MRS_ADDR_LAST_TPH : `MRS_ADDR_LAST_TP;
                    st_next.count = 4'h0;
                end
            end
            mrs_pkg::MRS_ADDR: st_next.state = mrs_pkg::MRS_DATA;
            mrs_pkg::MRS_DATA: begin
                if (LINK.rd_valid) begin
                    st_next.shift = {st_reg.shift[55:0], LINK.rd_data};
                    st_next.count = st_reg.count + 4'h1;
                    if (`MRS_ADDR_FIRST + {4'h0, st_reg.count} == st_reg.last) begin
                        st_next.state = mrs_pkg::MRS_END;
                    end
                end
            end
            mrs_pkg::MRS_END: begin
                st_next.state = mrs_pkg::MRS_IDLE;
                st_next.done = 1'b1;
                st_next.res.press = st_reg.shift[63:44];
                st_next.res.temp = st_reg.shift[39:20];
                st_next.res.hum = (st_reg.last == `MRS_ADDR_LAST_TPH) ? st_reg.shift[15:0] : st_reg.res.hum;
                if (st_reg.last != `MRS_ADDR_LAST_TPH) begin
                    st_next.res.press = st_reg.shift[47:28];
                    st_next.res.temp = st_reg.shift[23:4];
                end
            end
            default: st_next.state = mrs_pkg::MRS_IDLE;
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // One burst from the first result address
    assign LINK.start = (st_reg.state == mrs_pkg::MRS_ADDR);
    assign LINK.start_addr = `MRS_ADDR_FIRST;
    assign LINK.burst_active = (st_reg.state == mrs_pkg::MRS_ADDR) || (st_reg.state == mrs_pkg::MRS_DATA);
    assign LINK.byte_req = (st_reg.state == mrs_pkg::MRS_DATA) && !LINK.rd_valid;
    assign LINK.spi_mode = st_reg.spi;
    assign LINK.serial_select_low = !(st_reg.spi && LINK.burst_active);
    assign LINK.i2c_stop = !st_reg.spi && (st_reg.state == mrs_pkg::MRS_END);
    assign BUSY = (st_reg.state != mrs_pkg::MRS_IDLE);
    assign DONE = st_reg.done;
    assign PRESS = st_reg.res.press;
    assign TEMP = st_reg.res.temp;
    assign HUM = st_reg.res.hum;
endmodule // mrs_host

// ===== sim/mrs_props.sv
`timescale 1ns/10ps
module mrs_props (
    input wire logic CLOCK, // Clock
    input wire logic SYS_RST, // Reset
    input wire logic burst_active, // Burst
    input wire logic [7:0] start_addr, // First addr
    input wire logic start, // Start
    input wire logic byte_req, // Byte ask
    input wire logic rd_valid, // Byte out
    input wire logic spi_mode, // SPI
    input wire logic serial_select_low, // Select
    input wire logic i2c_stop // STOP
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);
    property p_first; start |-> start_addr == 8'hF7; endproperty
    a_first: assert property (p_first) else $error("bad start addr");
    property p_answer; byte_req && burst_active |=> rd_valid; endproperty
    a_answer: assert property (p_answer) else $error("byte late");
    property p_nospur; rd_valid |-> $past(byte_req); endproperty
    a_nospur: assert property (p_nospur) else $error("stray byte");
    property p_sel; burst_active && spi_mode |-> !serial_select_low; endproperty
    a_sel: assert property (p_sel) else $error("select high in burst");
    property p_stop; i2c_stop |-> !spi_mode; endproperty
    a_stop: assert property (p_stop) else $error("STOP in SPI");
    property p_stop_end; i2c_stop |=> !burst_active; endproperty
    a_stop_end: assert property (p_stop_end) else $error("burst after STOP");
    property p_stop_pulse; i2c_stop |=> !i2c_stop; endproperty
    a_stop_pulse: assert property (p_stop_pulse) else $error("STOP too long");
    property p_len; $rose(burst_active) |-> burst_active[*8] ##[1:20] !burst_active; endproperty
    a_len: assert property (p_len) else $error("burst length");
    c_stop: cover property (i2c_stop);
    c_sel: cover property ($rose(serial_select_low));
    c_spi: cover property (start && spi_mode);
endmodule // mrs_props

// ===== sim/measurement_readout_shadowing_tb.sv
`timescale 1ns/10ps
module measurement_readout_shadowing_tb;
    logic CLOCK = 0, SYS_RST = 1, READ_REQ = 0, WITH_HUM = 0, USE_SPI = 0, CONV_DONE = 0, SKIP_PRESS = 0, SKIP_TEMP = 0;
    logic [19:0] CONV_PRESS = 20'h0, CONV_TEMP = 20'h0, PRESS, TEMP;
    logic [15:0] CONV_HUM = 16'h0, HUM;
    logic BUSY, DONE, SHADOW_PENDING;
    logic [56:0] exp_q[$];
    logic [56:0] e;
    logic [55:0] vis;
    int n_mismatch = 0, n_compared = 0, cyc = 0;
    always #2 CLOCK = ~CLOCK;
    mrs_link_if link ();
    mrs_device mrs_device_i (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .LINK(link), .CONV_DONE(CONV_DONE),
        .CONV_PRESS(CONV_PRESS), .CONV_TEMP(CONV_TEMP), .CONV_HUM(CONV_HUM), .SKIP_PRESS(SKIP_PRESS),
        .SKIP_TEMP(SKIP_TEMP), .SHADOW_PENDING(SHADOW_PENDING));
    mrs_host mrs_host_i (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .LINK(link), .READ_REQ(READ_REQ), .WITH_HUM(WITH_HUM),
        .USE_SPI(USE_SPI), .BUSY(BUSY), .DONE(DONE), .PRESS(PRESS), .TEMP(TEMP), .HUM(HUM));
    mrs_props mrs_props_i (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .burst_active(link.burst_active),
        .start_addr(link.start_addr), .start(link.start), .byte_req(link.byte_req), .rd_valid(link.rd_valid),
        .spi_mode(link.spi_mode), .serial_select_low(link.serial_select_low), .i2c_stop(link.i2c_stop));
    task automatic check(string what, logic [19:0] seen, logic [19:0] want);
        n_compared++;
        if (seen !== want) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic conv(input logic sp, st, output logic [55:0] r);
        r = 56'({$urandom, $urandom});
        @(posedge CLOCK);
        {CONV_PRESS, CONV_TEMP, CONV_HUM} <= r;
        SKIP_PRESS <= sp;
        SKIP_TEMP <= st;
        CONV_DONE <= 1'b1;
        @(posedge CLOCK);
        CONV_DONE <= 1'b0;
        if (sp) r[55:36] = 20'h80000;
        if (st) r[35:16] = 20'h80000;
    endtask
    // Read; n conversions land mid-burst and must wait in the shadow
    task automatic rd(input logic wh, spi, input int n);
        logic [55:0] r;
        @(posedge CLOCK);
        READ_REQ <= 1'b1;
        WITH_HUM <= wh;
        USE_SPI <= spi;
        exp_q.push_back({wh, vis});
        @(posedge CLOCK);
        READ_REQ <= 1'b0;
        repeat (n) begin
            conv(1'b0, 1'b0, r);
            #1 check("pending", {19'h0, SHADOW_PENDING}, 20'h1);
        end
        for (int i = 0; i < 100 && (i == 0 || BUSY !== 1'b0); i++) begin
            @(posedge CLOCK);
            #1;
        end
        check("idle", {19'h0, BUSY}, 20'h0);
        repeat (2) @(posedge CLOCK);
        if (n > 0) begin
            check("pending_clr", {19'h0, SHADOW_PENDING}, 20'h0);
            vis = r;
        end
    endtask
    always @(posedge CLOCK) begin
        cyc <= cyc + 1;
        if (cyc > 3000) begin
            n_mismatch++;
            wrap_up();
        end
        if (DONE === 1'b1 && exp_q.size() == 0) begin
            check("done_unasked", 20'h1, 20'h0);
        end else if (DONE === 1'b1) begin
            e = exp_q.pop_front();
            check("press", PRESS, e[55:36]);
            check("temp", TEMP, e[35:16]);
            if (e[56]) check("hum", {4'h0, HUM}, {4'h0, e[15:0]});
        end
    end
    initial begin
        vis = {20'h80000, 20'h80000, 16'h8000};
        void'($urandom(99));
        repeat (16) @(posedge CLOCK);
        SYS_RST <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            rd(1'b1, k[0], 0);
            conv(k[0], k[1], vis);
            rd(k[1], k[0], k % 3);
        end
        rd(1'b1, 1'b1, 0);
        check("drained", 20'(exp_q.size()), 20'h0);
        wrap_up();
    end
endmodule // measurement_readout_shadowing_tb
